/* shared/hc_ctrl_pkg.sv */
/*
 Host controller control and self-ID base pointer register bank: constants.
 Assumes a 20 MHz core clock and a plain address/strobe register port.
*/
// Contract
// (R1) Swap packet data unless swap disable set
// (R2) Permit flag loaded at init, software clears
// (R3) Host leaves enhancements alone without permit
// (R4) Host sets enhancement only with permit, link
// (R5) Link power status output follows its bit
// (R6) Posted writes accepted only when enabled
// (R7) Host changes posted write while link off
// (R8) Any reset clears link active
// (R9) Host sets link active, then bus reset
// (R10) Link inactive disconnects from the bus
// (R11) Software reset restores all controller registers; the code keeps the permit flag and the self-ID base pointer
// (R12) Software reset keeps host bus configuration
// (R13) Software reset flag reads one while busy
// (R14) Control reserved bits read zero
// (R15) Base pointer bits 31:11 only are writable
// (R16) Self-ID stored at 2 Kbyte aligned base
// (R17) Control register set 0x50, clear 0x54
// (R18) Ones set or clear; reads return value; clear writes leave LPS and link active unchanged
package hc_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL_SET = 8'h50;
   localparam logic [7:0] OFF_CTRL_CLR = 8'h54;
   localparam logic [7:0] OFF_SELF_ID_BASE = 8'h64;
   localparam int BIT_SWAP_DIS = 30;
   localparam int BIT_CFG_PERMIT = 23;
   localparam int BIT_ENH_EN = 22;
   localparam int BIT_LPS = 19;
   localparam int BIT_POSTED = 18;
   localparam int BIT_LINK = 17;
   localparam int BIT_SRST = 16;
   localparam int BASE_LSB = 11;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [3:0] SRST_CYCLES = 4'h8;
   localparam logic [3:0] INIT_CYCLES = 4'h3;
endpackage : hc_ctrl_pkg

/* rtl/sync2.sv */
/*
 Two-flop level synchroniser.
 Assumes the input is a slow level from outside the clock domain.
*/
`timescale 1ns/1ns
module sync2 (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_ff;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_ff <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_ff <= async_i;
         sync_o <= meta_ff;
      end
   end
endmodule : sync2

/* rtl/byte_swap.sv */
/*
 Registered byte swapper for packet data words.
 Assumes the swap control is on the same clock.
*/
`timescale 1ns/1ns
module byte_swap (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic swap_dis_i,
   input wire logic [31:0] data_i,
   output logic [31:0] data_o
);
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_o <= 32'h0000_0000;
      end else if (swap_dis_i) begin
         data_o <= data_i; // see (R1)
      end else begin
         data_o <= {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]}; // see (R1)
      end
   end
endmodule : byte_swap

/* rtl/hc_ctrl_regs.sv */
/*
 Host controller control set/clear register and self-ID base pointer.
 Assumes a single-cycle strobe register port and a 20 MHz core clock;
 the permit strap comes from outside the clock domain.
*/
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module hc_ctrl_regs (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [hc_ctrl_pkg::ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic cfg_permit_strap_i,
   input wire logic [31:0] pkt_data_i,
   output logic [31:0] pkt_data_o,
   input wire logic posted_req_i,
   output logic posted_accept_o,
   output logic link_power_status_o,
   output logic link_active_o,
   output logic enhancement_enable_o,
   output logic ctrl_reset_o,
   output logic [31:0] self_id_base_o
);
   import hc_ctrl_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SRST} phase_t;
   phase_t phase_ff;
   logic [3:0] cnt_ff;
   logic permit_sync;
   logic data_swap_disable_ff;
   logic enhancement_config_permit_ff;
   logic enhancement_enable_ff;
   logic link_power_status_ff;
   logic posted_write_on_ff;
   logic link_active_ff;
   logic software_reset_request_ff;
   logic [31:BASE_LSB] base_ff;
   logic wr_set;
   logic wr_clr;
   logic wr_base;
   logic soft_done;
   logic [31:0] ctrl_value;

   sync2 u_permit_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(cfg_permit_strap_i),
      .sync_o(permit_sync)
   );

   byte_swap u_swap (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .swap_dis_i(data_swap_disable_ff),
      .data_i(pkt_data_i),
      .data_o(pkt_data_o)
   );

   // ****************************************
   // Decode
   // ****************************************
   assign wr_set = wr_i && (addr_i == OFF_CTRL_SET); // see (R17)
   assign wr_clr = wr_i && (addr_i == OFF_CTRL_CLR); // see (R17)
   assign wr_base = wr_i && (addr_i == OFF_SELF_ID_BASE);
   assign soft_done = (phase_ff == ST_SRST) && (cnt_ff == 4'h1);

   always_comb begin
      ctrl_value = 32'h0000_0000; // see (R14)
      ctrl_value[BIT_SWAP_DIS] = data_swap_disable_ff;
      ctrl_value[BIT_CFG_PERMIT] = enhancement_config_permit_ff;
      ctrl_value[BIT_ENH_EN] = enhancement_enable_ff;
      ctrl_value[BIT_LPS] = link_power_status_ff;
      ctrl_value[BIT_POSTED] = posted_write_on_ff;
      ctrl_value[BIT_LINK] = link_active_ff;
      ctrl_value[BIT_SRST] = software_reset_request_ff; // see (R13)
   end

   // ****************************************
   // Init and software reset sequencing
   // ****************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase_ff <= ST_INIT;
         cnt_ff <= INIT_CYCLES;
      end else begin
         unique case (phase_ff)
            ST_INIT: begin
               if (cnt_ff == 4'h1) begin
                  phase_ff <= ST_RUN;
               end
               cnt_ff <= cnt_ff - 4'h1;
            end
            ST_RUN: begin
               if (wr_set && wdata_i[BIT_SRST]) begin
                  phase_ff <= ST_SRST;
                  cnt_ff <= SRST_CYCLES;
               end
            end
            ST_SRST: begin
               if (cnt_ff == 4'h1) begin
                  phase_ff <= ST_RUN;
               end
               cnt_ff <= cnt_ff - 4'h1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         software_reset_request_ff <= 1'b0;
      end else if (phase_ff == ST_RUN && wr_set && wdata_i[BIT_SRST]) begin
         software_reset_request_ff <= 1'b1; // see (R13)
      end else if (soft_done) begin
         software_reset_request_ff <= 1'b0; // see (R13)
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reset_o <= 1'b0;
      end else begin
         ctrl_reset_o <= (phase_ff == ST_SRST); // see (R11)
      end
   end

   // ****************************************
   // Control flags
   // ****************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enhancement_config_permit_ff <= CTRL_RESET[BIT_CFG_PERMIT];
      end else if (phase_ff == ST_INIT && cnt_ff == 4'h1) begin
         enhancement_config_permit_ff <= permit_sync; // see (R2)
      end else if (wr_clr && wdata_i[BIT_CFG_PERMIT]) begin
         enhancement_config_permit_ff <= 1'b0; // see (R2)
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_swap_disable_ff <= CTRL_RESET[BIT_SWAP_DIS];
         enhancement_enable_ff <= CTRL_RESET[BIT_ENH_EN];
         link_power_status_ff <= CTRL_RESET[BIT_LPS];
         posted_write_on_ff <= CTRL_RESET[BIT_POSTED];
         link_active_ff <= CTRL_RESET[BIT_LINK];
      end else if (phase_ff == ST_SRST) begin
         data_swap_disable_ff <= CTRL_RESET[BIT_SWAP_DIS]; // see (R11)
         enhancement_enable_ff <= CTRL_RESET[BIT_ENH_EN];
         link_power_status_ff <= CTRL_RESET[BIT_LPS];
         posted_write_on_ff <= CTRL_RESET[BIT_POSTED];
         link_active_ff <= 1'b0; // see (R8)
      end else if (wr_set) begin
         data_swap_disable_ff <= data_swap_disable_ff | wdata_i[BIT_SWAP_DIS]; // see (R18)
         enhancement_enable_ff <= enhancement_enable_ff | wdata_i[BIT_ENH_EN];
         link_power_status_ff <= link_power_status_ff | wdata_i[BIT_LPS];
         posted_write_on_ff <= posted_write_on_ff | wdata_i[BIT_POSTED];
         link_active_ff <= link_active_ff | wdata_i[BIT_LINK];
      end else if (wr_clr) begin
         data_swap_disable_ff <= data_swap_disable_ff & ~wdata_i[BIT_SWAP_DIS]; // see (R18)
         enhancement_enable_ff <= enhancement_enable_ff & ~wdata_i[BIT_ENH_EN];
         posted_write_on_ff <= posted_write_on_ff & ~wdata_i[BIT_POSTED];
      end
   end

   // ****************************************
   // Self-ID base pointer, kept across software reset
   // ****************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin // see (R12)
      if (!reset_n_i) begin
         base_ff <= BASE_RESET[31:BASE_LSB];
      end else if (wr_base) begin
         base_ff <= wdata_i[31:BASE_LSB]; // see (R15)
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i && (addr_i == OFF_CTRL_SET || addr_i == OFF_CTRL_CLR)) begin
         rdata_o <= ctrl_value; // see (R18)
      end else if (rd_i && addr_i == OFF_SELF_ID_BASE) begin
         rdata_o <= {base_ff, 11'h000}; // see (R15)
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_power_status_o <= 1'b0;
         link_active_o <= 1'b0;
         enhancement_enable_o <= 1'b0;
         posted_accept_o <= 1'b0;
         self_id_base_o <= 32'h0000_0000;
      end else begin
         link_power_status_o <= link_power_status_ff; // see (R5)
         link_active_o <= link_active_ff; // see (R10)
         enhancement_enable_o <= enhancement_enable_ff;
         posted_accept_o <= posted_req_i && posted_write_on_ff && link_active_ff; // see (R6)
         self_id_base_o <= {base_ff, 11'h000}; // see (R16)
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   AST_SRST_CLEARS_LINK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R8)
      phase_ff == ST_SRST |=> !link_active_ff)
      else $error("link active survived software reset");
   AST_SRST_HOLDS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R13)
      $rose(software_reset_request_ff) |-> software_reset_request_ff [*8] ##1 !software_reset_request_ff)
      else $error("software reset flag length wrong");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R14)
      rd_i && (addr_i == OFF_CTRL_SET || addr_i == OFF_CTRL_CLR) |=> (rdata_o & 32'hBF30_FFFF) == 32'h0000_0000)
      else $error("reserved control bits nonzero");
   AST_BASE_LOW_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R15)
      self_id_base_o[10:0] == 11'h000)
      else $error("base pointer low bits nonzero");
   AST_BASE_WRITE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R16)
      wr_base |=> ##1 self_id_base_o[31:11] == $past(wdata_i[31:11], 2))
      else $error("base pointer not updated");
   AST_LPS_OUT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R5)
      ##1 link_power_status_o == $past(link_power_status_ff))
      else $error("link power status output mismatch");
   AST_POSTED_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R6)
      !posted_write_on_ff |=> !posted_accept_o)
      else $error("posted write accepted while disabled");
   AST_LINK_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R10)
      !link_active_ff |=> !link_active_o && !posted_accept_o)
      else $error("link activity while inactive");
   AST_SET_CLR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R18)
      phase_ff == ST_RUN && wr_clr && wdata_i[BIT_POSTED] |=> !posted_write_on_ff)
      else $error("clear location did not clear");
   AST_SWAP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see (R1)
      !data_swap_disable_ff |=> pkt_data_o[7:0] == $past(pkt_data_i[31:24]))
      else $error("data not swapped");
   COV_SRST: cover property (@(posedge core_clk_i) $fell(software_reset_request_ff));
   COV_LINK: cover property (@(posedge core_clk_i) $rose(link_active_o));
   COV_POSTED: cover property (@(posedge core_clk_i) posted_accept_o);
endmodule : hc_ctrl_regs

/* testbench/testbench.sv */
/*
 Self-checking bench for the control set/clear register and self-ID base pointer.
 Assumes the register bank of hc_ctrl_regs with its own assertions inside it.
*/
`timescale 1ns/1ns
module testbench;
   import hc_ctrl_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_n_i;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic cfg_permit_strap_i = 1'b1;
   logic [31:0] pkt_data_i = 32'h0;
   logic posted_req_i = 1'b0;
   logic [31:0] rdata_o, pkt_data_o, self_id_base_o;
   logic posted_accept_o, link_power_status_o, link_active_o, enhancement_enable_o, ctrl_reset_o;
   logic [63:0] exp_q[$];
   logic [63:0] note;
   logic rd_seen = 1'b0;
   logic [31:0] base_val, pkt_val;
   int n_errors = 0;
   int compares = 0;
   int seed = 32'h4EB465E5;
   int k;

   always #25 core_clk_i = ~core_clk_i;

   hc_ctrl_regs DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_permit_strap_i(cfg_permit_strap_i),
      .pkt_data_i(pkt_data_i), .pkt_data_o(pkt_data_o), .posted_req_i(posted_req_i),
      .posted_accept_o(posted_accept_o), .link_power_status_o(link_power_status_o),
      .link_active_o(link_active_o), .enhancement_enable_o(enhancement_enable_o),
      .ctrl_reset_o(ctrl_reset_o), .self_id_base_o(self_id_base_o));

   // ******************************
   // Comparison and closing
   // ******************************
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task summarize;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   // ******************************
   // Bus tasks
   // ******************************
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back({mask, exp & mask});
      @(posedge core_clk_i);
      rd_i <= 1'b0;
   endtask : rd

   task pkt(input logic swap);
      logic [31:0] pkt_exp;
      pkt_val = $random(seed);
      pkt_exp = swap ? {pkt_val[7:0], pkt_val[15:8], pkt_val[23:16], pkt_val[31:24]} : pkt_val;
      @(posedge core_clk_i);
      pkt_data_i <= pkt_val;
      repeat (2) @(posedge core_clk_i);
      #1;
      check("pkt_data_o", pkt_data_o, pkt_exp);
   endtask : pkt

   task wait_reset(input logic level);
      k = 0;
      while (ctrl_reset_o !== level && k < 30) begin
         @(posedge core_clk_i);
         k++;
      end
      if (ctrl_reset_o !== level) begin
         n_errors++;
         $display("[ERR] ctrl_reset_o wait ran out");
         summarize();
      end
   endtask : wait_reset

   // ******************************
   // Read data watcher
   // ******************************
   always @(posedge core_clk_i) begin
      if (rd_seen) begin
         note = exp_q.pop_front();
         check("rdata_o", rdata_o & note[63:32], note[31:0]);
      end
      rd_seen <= rd_i;
   end

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      reset_n_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rd(OFF_CTRL_SET, 32'h0080_0000, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0, 32'hFFFF_FFFF);
      wr(OFF_CTRL_SET, 32'h400C_0000);
      wr(OFF_CTRL_CLR, 32'h0004_0000);
      rd(OFF_CTRL_SET, 32'h4088_0000, 32'hFFFF_FFFF);
      wr(OFF_CTRL_SET, 32'h0004_0000);
      wr(OFF_CTRL_SET, 32'h0002_0000);
      wr(OFF_CTRL_SET, 32'h0040_0000);
      rd(OFF_CTRL_CLR, 32'h40CE_0000, 32'hFFFF_FFFF);
      repeat (3) @(posedge core_clk_i);
      check("link_active_o", {31'h0, link_active_o}, 32'h1);
      check("link_power_status_o", {31'h0, link_power_status_o}, 32'h1);
      check("enhancement_enable_o", {31'h0, enhancement_enable_o}, 32'h1);
      posted_req_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      check("posted_accept_o", {31'h0, posted_accept_o}, 32'h1);
      pkt(1'b0);
      base_val = $random(seed);
      wr(OFF_SELF_ID_BASE, base_val);
      rd(OFF_SELF_ID_BASE, base_val & 32'hFFFF_F800, 32'hFFFF_FFFF);
      repeat (2) @(posedge core_clk_i);
      check("self_id_base_o", self_id_base_o, base_val & 32'hFFFF_F800);
      wr(OFF_CTRL_CLR, 32'h40C0_0000);
      rd(OFF_CTRL_SET, 32'h000E_0000, 32'hFFFF_FFFF);
      wr(OFF_CTRL_SET, 32'h0080_0000);
      rd(OFF_CTRL_SET, 32'h000E_0000, 32'hFFFF_FFFF);
      repeat (3) @(posedge core_clk_i);
      check("enhancement_enable_o", {31'h0, enhancement_enable_o}, 32'h0);
      pkt(1'b1);
      wr(OFF_CTRL_SET, 32'h0001_0000);
      rd(OFF_CTRL_SET, 32'h0001_0000, 32'h0001_0000);
      wait_reset(1'b1);
      wr(OFF_CTRL_SET, 32'h4000_0000);
      wait_reset(1'b0);
      rd(OFF_CTRL_SET, 32'h0, 32'hFFFF_FFFF);
      rd(OFF_SELF_ID_BASE, base_val & 32'hFFFF_F800, 32'hFFFF_FFFF);
      repeat (3) @(posedge core_clk_i);
      check("link_active_o", {31'h0, link_active_o}, 32'h0);
      check("link_power_status_o", {31'h0, link_power_status_o}, 32'h0);
      wr(OFF_CTRL_SET, 32'h0002_0000);
      repeat (3) @(posedge core_clk_i);
      check("posted_accept_o", {31'h0, posted_accept_o}, 32'h0);
      check("link_active_o", {31'h0, link_active_o}, 32'h1);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1;
      check("link_active_o", {31'h0, link_active_o}, 32'h0);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rd(OFF_CTRL_SET, 32'h0080_0000, 32'hFFFF_FFFF);
      repeat (3) @(posedge core_clk_i);
      summarize();
   end
endmodule : testbench
